// File: verification/sbdma_host_model.sv
// Purpose : host arbiter and memory slave seen by the dma master
// Assumes : bus clock runs free at 80 ns, unrelated to ref clock
// Notes   : counters are read by the bench, cleared by clr_i
`timescale 1ns/1ps
module sbdma_host_model (
   input  wire logic                   ref_clk_i,
   input  wire logic                   rst_n_i,
   input  wire logic                   clr_i,
   input  wire logic                   slow_i,
   input  wire logic                   err_en_i,
   input  wire logic                   rls_en_i,
   input  wire logic                   bus_request_n_i,
   input  wire logic                   bus_owned_n_i,
   input  wire logic                   write_strobe_n_i,
   input  wire logic                   data_strobe_n_i,
   input  wire logic                   byte_high_enable_n_i,
   input  wire logic                   addr_latch_enable_i,
   input  wire logic                   ext_addr_latch_i,
   input  wire sbdma_pkg::sbdma_lane_t lane_i,
   output logic                        system_bus_clock_o,
   output logic                        slave_ready_n_o,
   output logic                        bus_grant_n_o,
   output logic                        bus_busy_in_n_o,
   output logic                        bus_release_n_o,
   output logic                        bus_error_n_o,
   output logic [15:0]                 bus_data_o
);
   import sbdma_pkg::*;
   logic [15:0] n_wr, n_ale, n_xal, n_own, wlen, wcnt, data, oe;
   logic        bhe_lo, act_q, ale_q, xal_q, own_q;
   wire         act = !write_strobe_n_i || !data_strobe_n_i;
   initial begin
      system_bus_clock_o = 1'b0;
      bus_grant_n_o = 1'b1;
      bus_data_o = 16'h0ff1; // fixed read pattern, not symmetric across lanes
      #13;
      forever #40 system_bus_clock_o = ~system_bus_clock_o;
   end
   // grant trails the request by a bus clock, as a slow arbiter would
   always @(posedge system_bus_clock_o) bus_grant_n_o <= bus_request_n_i;
   always @(posedge ref_clk_i) begin
      act_q <= act;
      ale_q <= addr_latch_enable_i;
      xal_q <= ext_addr_latch_i;
      own_q <= bus_owned_n_i;
      bus_busy_in_n_o <= 1'b1;
      wcnt <= act ? wcnt + 16'h1 : 16'h0;
      slave_ready_n_o <= slow_i && act && wcnt < 16'h40;
      bus_release_n_o <= !(rls_en_i && n_wr != 16'h0 && !bus_owned_n_i);
      bus_error_n_o <= bus_owned_n_i || (bus_error_n_o && !(err_en_i && act));
      if (act) begin
         data <= lane_i.ad_o;
         oe <= lane_i.ad_oe;
      end
      if (act_q && !act) begin
         n_wr <= n_wr + 16'h1;
         wlen <= wcnt;
      end
      if (!ale_q && addr_latch_enable_i) n_ale <= n_ale + 16'h1;
      if (!xal_q && ext_addr_latch_i) n_xal <= n_xal + 16'h1;
      if (own_q && !bus_owned_n_i) n_own <= n_own + 16'h1;
      if (!byte_high_enable_n_i) bhe_lo <= 1'b1;
      if (!rst_n_i || clr_i) begin
         {n_wr, n_ale, n_xal, n_own, wlen, data, oe} <= '0;
         bhe_lo <= 1'b0;
      end
   end
endmodule

// File: verification/sbdma_master_monitor.sv
// Purpose : port checker for the dma bus master
// Assumes : one domain, bus clock about 16 ref clocks
// Notes   : bound to every sbdma_master instance
`timescale 1ns/1ps
module sbdma_master_monitor (
   input wire logic                   ref_clk_i,
   input wire logic                   rst_n_i,
   input wire logic                   slave_ready_n_i,
   input wire logic                   bus_busy_in_n_i,
   input wire sbdma_pkg::sbdma_lane_t lane_o,
   input wire logic                   write_strobe_n_o,
   input wire logic                   addr_latch_enable_o,
   input wire logic                   addr_strobe_n_o,
   input wire logic                   read_not_write_o,
   input wire logic                   upper_data_strobe_n_o,
   input wire logic                   buffer_enable_n_o,
   input wire logic                   buffer_direction_o,
   input wire logic                   bus_owned_n_o
);
   import sbdma_pkg::*;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   // ----------------------------------------
   // sequences and properties
   // ----------------------------------------
   sequence s_ws_fall; $fell(write_strobe_n_o); endsequence
   sequence s_ws_hold; !write_strobe_n_o [*8]; endsequence
   sequence s_ale_drop; ##[1:40] !addr_latch_enable_o; endsequence
   property p_own; |lane_o.ad_oe |-> !bus_owned_n_o; endproperty
   property p_wr_drive;
      !write_strobe_n_o |-> buffer_direction_o && !buffer_enable_n_o && |lane_o.ad_oe;
   endproperty
   property p_lane_whole;
      lane_o.ad_oe[15:8] inside {8'h00, 8'hff} && lane_o.ad_oe[7:0] inside {8'h00, 8'hff};
   endproperty
   property p_par_lo; lane_o.par_oe[0] |-> ^{lane_o.ad_o[7:0], lane_o.par_o[0]}; endproperty
   property p_par_hi; lane_o.par_oe[1] |-> ^{lane_o.ad_o[15:8], lane_o.par_o[1]}; endproperty
   property p_ws_len; s_ws_fall |-> s_ws_hold; endproperty
   property p_wait; slave_ready_n_i && !write_strobe_n_o |=> !write_strobe_n_o; endproperty
   property p_ale; $rose(addr_latch_enable_o) |-> !bus_owned_n_o ##0 s_ale_drop; endproperty
   property p_ds_late;
      $fell(upper_data_strobe_n_o) && !read_not_write_o |-> $past(addr_strobe_n_o, 8) == 1'b0;
   endproperty
   property p_ds_xcv;
      !read_not_write_o && !upper_data_strobe_n_o |-> buffer_direction_o && !buffer_enable_n_o;
   endproperty
   property p_busy; $fell(bus_owned_n_o) |-> $past(bus_busy_in_n_i, 4); endproperty
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   a_own:        assert property (p_own) else $error("bus driven while not owned");
   a_wr_drive:   assert property (p_wr_drive) else $error("write strobe without drive");
   a_lane_whole: assert property (p_lane_whole) else $error("partial byte lane");
   a_par_lo:     assert property (p_par_lo) else $error("low lane parity even");
   a_par_hi:     assert property (p_par_hi) else $error("high lane parity even");
   a_ws_len:     assert property (p_ws_len) else $error("write strobe too short");
   a_wait:       assert property (p_wait) else $error("strobe ended in wait");
   a_ale:        assert property (p_ale) else $error("latch pulse bad");
   a_ds_late:    assert property (p_ds_late) else $error("data strobe too early");
   a_ds_xcv:     assert property (p_ds_xcv) else $error("transceiver not out");
   a_busy:       assert property (p_busy) else $error("owned while busy");
endmodule

bind sbdma_master sbdma_master_monitor sbdma_master_monitor_inst (.*);

// File: verification/sbdma_master_test.sv
// Purpose : self-checking bench for the dma bus master
// Assumes : no wait states unless slow is set, then ready is held off for the first 64 ref clocks of each strobe
// Notes   : one task per scenario, host model answers the bus
`timescale 1ns/1ps
module sbdma_master_test;
   import sbdma_pkg::*;
   logic ref_clk_i = 1'b0, rst_n_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
   logic [3:0] avs_address_i = 4'h0;
   logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, st;
   logic transfer_ack_n_i = 1'b1, addr_strobe_n_i = 1'b1;
   logic upper_data_strobe_n_i = 1'b1, lower_data_strobe_n_i = 1'b1;
   logic clr = 1'b0, slow = 1'b0, err_en = 1'b0, rls_en = 1'b0;
   logic avs_waitrequest_o, system_bus_clock_i, slave_ready_n_i, bus_grant_n_i;
   logic bus_busy_in_n_i, bus_release_n_i, bus_error_n_i, write_strobe_n_o;
   logic read_strobe_n_o, byte_high_enable_n_o, addr_latch_enable_o, ext_addr_latch_o;
   logic addr_strobe_n_o, read_not_write_o, upper_data_strobe_n_o, lower_data_strobe_n_o;
   logic ctl_oe_o, buffer_enable_n_o, buffer_direction_o, bus_owned_n_o, bus_request_n_o;
   logic [15:0] muxed_addr_data_bus_i;
   sbdma_lane_t lane_o;
   int bad_count = 0, checked = 0;
   wire [15:0] n_wr = sbdma_host_model_inst.n_wr, n_own = sbdma_host_model_inst.n_own,
               n_ale = sbdma_host_model_inst.n_ale, n_xal = sbdma_host_model_inst.n_xal,
               wlen = sbdma_host_model_inst.wlen, data = sbdma_host_model_inst.data,
               oe = sbdma_host_model_inst.oe;
   wire bhe_lo = sbdma_host_model_inst.bhe_lo;
   always #2.5 ref_clk_i = ~ref_clk_i;
   sbdma_master sbdma_master_inst (.*);
   sbdma_host_model sbdma_host_model_inst (
      .ref_clk_i, .rst_n_i, .clr_i(clr), .slow_i(slow), .err_en_i(err_en),
      .rls_en_i(rls_en), .bus_request_n_i(bus_request_n_o), .bus_owned_n_i(bus_owned_n_o),
      .write_strobe_n_i(write_strobe_n_o),
      .data_strobe_n_i(upper_data_strobe_n_o & lower_data_strobe_n_o),
      .byte_high_enable_n_i(byte_high_enable_n_o), .addr_latch_enable_i(addr_latch_enable_o),
      .ext_addr_latch_i(ext_addr_latch_o), .lane_i(lane_o),
      .system_bus_clock_o(system_bus_clock_i), .slave_ready_n_o(slave_ready_n_i),
      .bus_grant_n_o(bus_grant_n_i), .bus_busy_in_n_o(bus_busy_in_n_i),
      .bus_release_n_o(bus_release_n_i), .bus_error_n_o(bus_error_n_i),
      .bus_data_o(muxed_addr_data_bus_i));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic ok, input string m);
      checked++;
      if (ok !== 1'b1) begin
         bad_count++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask
   task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= 1'b1;
      do @(posedge ref_clk_i); while (avs_waitrequest_o !== 1'b0);
      avs_write_i <= 1'b0;
   endtask
   task automatic bus_rd(input logic [3:0] a);
      @(posedge ref_clk_i);
      avs_address_i <= a;
      avs_read_i <= 1'b1;
      do @(posedge ref_clk_i); while (avs_waitrequest_o !== 1'b0);
      st = avs_readdata_o;
      avs_read_i <= 1'b0;
   endtask
   // bits: go, write, strobe pair, wide, burst, byte
   task automatic run(input logic [5:0] b, input logic [15:0] a, d, n, input logic s, e, r);
      @(posedge ref_clk_i);
      slow <= s;
      err_en <= e;
      rls_en <= r;
      clr <= 1'b1;
      @(posedge ref_clk_i);
      clr <= 1'b0;
      bus_wr(ADDR_OFS, {16'h0000, a});
      bus_wr(DATA_OFS, {16'h0000, d});
      bus_wr(CTRL_OFS, {n, 10'h000, b});
      st = 32'h1;
      for (int i = 0; i < 3000 && st[STAT_BUSY_BIT] !== 1'b0; i++) bus_rd(STAT_OFS);
      chk(st[STAT_BUSY_BIT] === 1'b0, "transfer never ended");
      repeat (200) @(posedge ref_clk_i);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset();
      bus_rd(STAT_OFS);
      chk(st === 32'h0, "status reset");
      bus_rd(CTRL_OFS);
      chk(st === CTRL_RST, "control reset");
      bus_rd(4'h2);
      chk(st === 32'h0, "unmapped read");
      chk(bus_owned_n_o === 1'b1 && bus_request_n_o === 1'b1, "idle bus");
      $display("test reset done");
   endtask
   task automatic t_word();
      run(6'h1b, 16'h0010, 16'ha5c3, 16'h2, 1'b0, 1'b0, 1'b0);
      chk(st[STAT_DONE_BIT] === 1'b1 && n_wr === 16'h2, "word count");
      chk(data === 16'ha5c3 && oe === 16'hffff, "word lanes");
      chk(bhe_lo === 1'b1, "word high enable");
      chk(n_ale === 16'h2, "latch per cycle");
      chk(n_xal === 16'h1 && n_own === 16'h1, "one extended latch in burst");
      chk(wlen >= 16'd20 && wlen <= 16'd44, "strobe length");
      $display("test word done");
   endtask
   task automatic t_byte();
      run(6'h2b, 16'h0012, 16'h00c3, 16'h2, 1'b0, 1'b0, 1'b1);
      chk(data[7:0] === 8'hc3 && oe === 16'h00ff, "byte lane");
      chk(bhe_lo === 1'b1, "byte high enable");
      chk(n_xal === 16'h2, "extended latch per steal");
      chk(n_own === 16'h2 && n_wr === 16'h2, "release ignored in steal");
      $display("test byte done");
   endtask
   task automatic t_narrow();
      run(6'h13, 16'h0020, 16'h005a, 16'h1, 1'b0, 1'b0, 1'b0);
      chk(data[7:0] === 8'h5a && oe[15:8] === 8'h00 && bhe_lo === 1'b0, "8-bit lane");
      $display("test narrow done");
   endtask
   task automatic t_slow();
      run(6'h1b, 16'h0030, 16'h1234, 16'h1, 1'b1, 1'b0, 1'b0);
      chk(wlen > 16'd64 && n_wr === 16'h1 && data === 16'h1234, "wait states");
      $display("test slow done");
   endtask
   task automatic t_pair();
      run(6'h1f, 16'h0040, 16'h8001, 16'h2, 1'b0, 1'b0, 1'b0);
      chk(n_wr === 16'h2 && data === 16'h8001 && oe === 16'hffff, "pair write");
      chk(n_ale === 16'h2, "pair latch");
      $display("test pair done");
   endtask
   task automatic t_release();
      run(6'h1b, 16'h0050, 16'h0f0f, 16'h4, 1'b0, 1'b0, 1'b1);
      chk(n_wr === 16'h4 && n_own >= 16'h2, "release and request again");
      chk(st[STAT_DONE_BIT] === 1'b1, "release done");
      $display("test release done");
   endtask
   task automatic t_error();
      run(6'h1b, 16'h0060, 16'hffff, 16'h4, 1'b0, 1'b1, 1'b0);
      chk(st[STAT_ERR_BIT] === 1'b1 && n_wr < 16'h4, "bus error abort");
      $display("test error done");
   endtask
   task automatic t_read();
      run(6'h09, 16'h0070, 16'h0000, 16'h1, 1'b0, 1'b0, 1'b0);
      bus_rd(DATA_OFS);
      chk(st === 32'h0000_8ff0, "read data lanes");
      $display("test read done");
   endtask
   initial begin
      repeat (60000) @(posedge ref_clk_i);
      bad_count++;
      close_out();
   end
   initial begin
      repeat (4) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      t_reset();
      t_word();
      t_byte();
      t_narrow();
      t_slow();
      t_pair();
      t_release();
      t_error();
      t_read();
      close_out();
   end
endmodule

// File: verilog/sbdma_master.sv
// Purpose : dma bus master on a multiplexed 16-bit address/data system bus
// Assumes : system bus clock is much slower than ref_clk_i and is sampled
// Notes   : both personalities share one cycle sequencer; reads capture data on T3 end
`timescale 1ns/1ps
module sbdma_master (
   input  wire logic                 ref_clk_i,
   input  wire logic                 rst_n_i,
   input  wire logic [3:0]           avs_address_i,
   input  wire logic                 avs_read_i,
   input  wire logic                 avs_write_i,
   input  wire logic [31:0]          avs_writedata_i,
   output logic [31:0]               avs_readdata_o,
   output logic                      avs_waitrequest_o,
   input  wire logic                 system_bus_clock_i,
   input  wire logic                 slave_ready_n_i,
   input  wire logic                 bus_grant_n_i,
   input  wire logic                 bus_busy_in_n_i,
   input  wire logic                 bus_release_n_i,
   input  wire logic                 bus_error_n_i,
   input  wire logic                 transfer_ack_n_i,
   input  wire logic                 addr_strobe_n_i,
   input  wire logic                 upper_data_strobe_n_i,
   input  wire logic                 lower_data_strobe_n_i,
   input  wire logic [15:0]          muxed_addr_data_bus_i,
   output sbdma_pkg::sbdma_lane_t    lane_o,
   output logic                      write_strobe_n_o,
   output logic                      read_strobe_n_o,
   output logic                      byte_high_enable_n_o,
   output logic                      addr_latch_enable_o,
   output logic                      ext_addr_latch_o,
   output logic                      addr_strobe_n_o,
   output logic                      read_not_write_o,
   output logic                      upper_data_strobe_n_o,
   output logic                      lower_data_strobe_n_o,
   output logic                      ctl_oe_o,
   output logic                      buffer_enable_n_o,
   output logic                      buffer_direction_o,
   output logic                      bus_owned_n_o,
   output logic                      bus_request_n_o
);
   import sbdma_pkg::*;

   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   localparam int NSYNC = 10;
   logic [NSYNC-1:0] raw_in;
   logic [NSYNC-1:0] s1_r;
   logic [NSYNC-1:0] s2_r;
   logic [15:0]      ad1_r;
   logic [15:0]      ad2_r;
   logic             clk_d_r;
   assign raw_in = {system_bus_clock_i, slave_ready_n_i, bus_grant_n_i, bus_busy_in_n_i,
                    bus_release_n_i, bus_error_n_i, transfer_ack_n_i, addr_strobe_n_i,
                    upper_data_strobe_n_i, lower_data_strobe_n_i};
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         s1_r <= '1;
         s2_r <= '1;
         ad1_r <= 16'h0000;
         ad2_r <= 16'h0000;
         clk_d_r <= 1'b1;
      end else begin
         s1_r <= raw_in;
         s2_r <= s1_r;
         ad1_r <= muxed_addr_data_bus_i;
         ad2_r <= ad1_r;
         clk_d_r <= s2_r[NSYNC-1];
      end
   end
   logic bclk_s, rdy_n_s, gnt_n_s, bsy_n_s, rls_n_s, err_n_s, dtack_n_s;
   logic as_n_s, uds_n_s, lds_n_s;
   assign {bclk_s, rdy_n_s, gnt_n_s, bsy_n_s, rls_n_s, err_n_s, dtack_n_s,
           as_n_s, uds_n_s, lds_n_s} = s2_r;
   logic rise, fall;
   assign rise = bclk_s & ~clk_d_r;
   assign fall = ~bclk_s & clk_d_r;

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   sbdma_cfg_t   cfg_r;
   logic [23:0]  addr_r;
   logic [15:0]  wdata_r;
   logic [15:0]  rdata_r;
   logic [15:0]  left_r;
   logic         busy_r, err_r, done_r, xal_due_r;
   sbdma_state_t st_r;
   logic         first_r, steal_r;

   function automatic logic [15:0] lane_swap(input logic [15:0] v);
      logic [15:0] o;
      o = '0;
      for (int i = 0; i < 16; i++) begin
         o[15-i] = v[i];
      end
      return o;
   endfunction

   function automatic logic [1:0] odd_par(input logic [15:0] v);
      return {~^v[15:8], ~^v[7:0]};
   endfunction

   logic bus_wr, bus_rd, cfg_hit, rd_ready_r;
   assign bus_wr = avs_write_i & ~avs_waitrequest_o;
   // a read waits one cycle so that the registered readdata stands at the accepting edge
   assign bus_rd = avs_read_i & ~rd_ready_r;
   assign avs_waitrequest_o = bus_rd;
   assign cfg_hit = bus_wr && (avs_address_i == CTRL_OFS);

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         cfg_r <= sbdma_cfg_t'(CTRL_RST[20:0]);
         addr_r <= 24'h000000;
         wdata_r <= 16'h0000;
      end else begin
         if (cfg_hit && !busy_r) begin
            cfg_r.write       <= avs_writedata_i[CTRL_WRITE_BIT];
            cfg_r.strobe_pair <= avs_writedata_i[CTRL_MODE_BIT];
            cfg_r.wide        <= avs_writedata_i[CTRL_WIDE_BIT];
            cfg_r.burst       <= avs_writedata_i[CTRL_BURST_BIT];
            cfg_r.byte_only   <= avs_writedata_i[CTRL_BYTE_BIT];
            cfg_r.count       <= avs_writedata_i[CTRL_CNT_LSB +: 16];
         end
         if (bus_wr && avs_address_i == ADDR_OFS && !busy_r) begin
            addr_r <= avs_writedata_i[23:0];
         end else if (st_r == SB_T4 && fall) begin
            addr_r <= addr_r + ((cfg_r.wide && !cfg_r.byte_only) ? 24'h2 : 24'h1);
         end
         if (bus_wr && avs_address_i == DATA_OFS) begin
            wdata_r <= avs_writedata_i[15:0];
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         rd_ready_r <= 1'b0;
      end else begin
         rd_ready_r <= avs_read_i & ~rd_ready_r;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         avs_readdata_o <= 32'h0000_0000;
      end else if (bus_rd) begin
         if (avs_address_i == CTRL_OFS) begin
            avs_readdata_o <= {cfg_r.count, 10'h000, cfg_r.byte_only, cfg_r.burst,
                               cfg_r.wide, cfg_r.strobe_pair, cfg_r.write, 1'b0};
         end else if (avs_address_i == ADDR_OFS) begin
            avs_readdata_o <= {8'h00, addr_r};
         end else if (avs_address_i == DATA_OFS) begin
            avs_readdata_o <= {16'h0000, rdata_r};
         end else if (avs_address_i == STAT_OFS) begin
            avs_readdata_o <= {left_r, 13'h0000, done_r, err_r, busy_r};
         end else begin
            avs_readdata_o <= 32'h0000_0000;
         end
      end
   end

   // ------------------------------------------------------------
   // cycle sequencer, stepped on bus clock edges
   // ------------------------------------------------------------
   logic own_ok;
   logic [1:0] edge_cnt_r;
   assign own_ok = ~bus_request_n_o & ~gnt_n_s & bsy_n_s & err_n_s &
                   (~cfg_r.strobe_pair | (as_n_s & uds_n_s & lds_n_s & dtack_n_s));
   logic last_xfer;
   assign last_xfer = (left_r == 16'h0001);

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         st_r <= SB_IDLE;
         busy_r <= 1'b0;
         err_r <= 1'b0;
         done_r <= 1'b0;
         left_r <= 16'h0000;
         edge_cnt_r <= 2'h0;
         first_r <= 1'b0;
         steal_r <= 1'b0;
         xal_due_r <= 1'b0;
         rdata_r <= 16'h0000;
      end else begin
         if (cfg_hit && avs_writedata_i[CTRL_GO_BIT] && !busy_r) begin
            busy_r <= 1'b1;
            err_r <= 1'b0;
            done_r <= 1'b0;
            left_r <= avs_writedata_i[CTRL_CNT_LSB +: 16];
            steal_r <= ~avs_writedata_i[CTRL_BURST_BIT];
            first_r <= 1'b1;
            st_r <= SB_REQ;
            edge_cnt_r <= 2'h0;
         end
         case (st_r)
            SB_REQ: begin
               // grant high on a fall (strobe pair only; any fall otherwise), request on the second rise
               if (fall && (gnt_n_s || !cfg_r.strobe_pair) && edge_cnt_r == 2'h0) begin
                  edge_cnt_r <= 2'h1;
               end else if (rise && edge_cnt_r != 2'h0) begin
                  if (edge_cnt_r == 2'h2) begin
                     st_r <= SB_OWN;
                     edge_cnt_r <= 2'h0;
                  end else begin
                     edge_cnt_r <= 2'h2;
                  end
               end
            end
            SB_OWN: begin
               if (fall && own_ok) begin
                  st_r <= SB_TXW;
               end
            end
            SB_TXW: begin
               if (fall) begin
                  st_r <= SB_TX;
                  xal_due_r <= first_r | steal_r | xal_due_r;
               end
            end
            SB_TX: if (fall) st_r <= SB_T1;
            SB_T1: if (fall) st_r <= SB_T2;
            SB_T2: if (fall) st_r <= SB_T3;
            SB_T3: begin
               if (fall && rdy_n_s == 1'b0) begin
                  st_r <= SB_T4;
                  if (!cfg_r.write) begin
                     rdata_r <= lane_swap(ad2_r);
                  end
               end
            end
            SB_T4: begin
               if (fall) begin
                  first_r <= 1'b0;
                  xal_due_r <= (addr_r[7:0] == 8'hff) ||
                               (addr_r[7:0] == 8'hfe && cfg_r.wide && !cfg_r.byte_only);
                  left_r <= left_r - 16'h0001;
                  if (last_xfer || steal_r || (!rls_n_s && cfg_r.burst)) begin
                     st_r <= SB_REL;
                  end else begin
                     st_r <= SB_TX;
                  end
               end
            end
            SB_REL: begin
               if (rise) begin
                  if (left_r == 16'h0000) begin
                     st_r <= SB_IDLE;
                     busy_r <= 1'b0;
                     done_r <= 1'b1;
                  end else begin
                     st_r <= SB_GAP;
                  end
               end
            end
            SB_GAP: if (rise) st_r <= SB_REQ;
            default: ;
         endcase
         if (!err_n_s && st_r inside {SB_TX, SB_T1, SB_T2, SB_T3, SB_T4}) begin
            st_r <= SB_IDLE;
            busy_r <= 1'b0;
            err_r <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // pin drive, registered
   // ------------------------------------------------------------
   logic in_cyc, word, hi_used, lo_used, odd;
   assign in_cyc = st_r inside {SB_TX, SB_T1, SB_T2, SB_T3, SB_T4};
   assign word = cfg_r.wide && !cfg_r.byte_only;
   assign odd = addr_r[0];
   assign hi_used = cfg_r.wide && (word || !odd);
   assign lo_used = !cfg_r.wide || word || odd;
   logic [15:0] wd_lanes;
   assign wd_lanes = word ? wdata_r : {wdata_r[7:0], wdata_r[7:0]};

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         lane_o <= '0;
         write_strobe_n_o <= 1'b1;
         read_strobe_n_o <= 1'b1;
         byte_high_enable_n_o <= 1'b1;
         addr_latch_enable_o <= 1'b0;
         ext_addr_latch_o <= 1'b0;
         addr_strobe_n_o <= 1'b1;
         read_not_write_o <= 1'b1;
         upper_data_strobe_n_o <= 1'b1;
         lower_data_strobe_n_o <= 1'b1;
         ctl_oe_o <= 1'b0;
         buffer_enable_n_o <= 1'b1;
         buffer_direction_o <= 1'b1;
         bus_owned_n_o <= 1'b1;
         bus_request_n_o <= 1'b1;
      end else begin
         bus_request_n_o <= !(st_r inside {SB_OWN, SB_TXW} || in_cyc ||
                              (st_r == SB_REQ && edge_cnt_r == 2'h2 && rise));
         bus_owned_n_o <= !(st_r == SB_TXW || in_cyc);
         ctl_oe_o <= (st_r == SB_TXW || in_cyc);
         addr_latch_enable_o <= (st_r == SB_TX);
         ext_addr_latch_o <= (st_r == SB_TX) && xal_due_r;
         buffer_direction_o <= !(in_cyc && !cfg_r.write);
         buffer_enable_n_o <= !(st_r inside {SB_T1, SB_T2, SB_T3});
         byte_high_enable_n_o <= !(in_cyc && hi_used && !cfg_r.strobe_pair);
         if (st_r == SB_TX) begin
            lane_o.ad_o <= {addr_r[15:8], addr_r[23:16]};
            lane_o.ad_oe <= 16'hffff;
            lane_o.par_o <= odd_par({addr_r[15:8], addr_r[23:16]});
            lane_o.par_oe <= 2'b11;
         end else if (in_cyc && cfg_r.write) begin
            lane_o.ad_o <= wd_lanes;
            lane_o.ad_oe <= {{8{hi_used}}, {8{lo_used}}};
            lane_o.par_o <= odd_par(wd_lanes);
            lane_o.par_oe <= {hi_used, lo_used};
         end else begin
            lane_o <= '0;
         end
         // strobe-pair personality
         if (cfg_r.strobe_pair) begin
            addr_strobe_n_o <= !(st_r inside {SB_T1, SB_T2, SB_T3});
            read_not_write_o <= !(in_cyc && cfg_r.write);
            upper_data_strobe_n_o <= !(st_r inside {SB_T2, SB_T3} && hi_used);
            lower_data_strobe_n_o <= !(st_r inside {SB_T2, SB_T3} && lo_used);
            write_strobe_n_o <= 1'b1;
            read_strobe_n_o <= 1'b1;
         end else begin
            // strobe spans T2 and T3, two bus clocks without waits
            write_strobe_n_o <= !(cfg_r.write && st_r inside {SB_T2, SB_T3});
            read_strobe_n_o <= !(!cfg_r.write && st_r inside {SB_T2, SB_T3});
            addr_strobe_n_o <= 1'b1;
            read_not_write_o <= 1'b1;
            upper_data_strobe_n_o <= 1'b1;
            lower_data_strobe_n_o <= 1'b1;
         end
      end
   end
endmodule

// File: verilog/sbdma_pkg.sv
// Purpose : constants and carriers for the system bus dma master
// Assumes : ref_clk_i at 200 MHz samples the system bus clock as a data input
// Notes   : register offsets are byte addresses on an Avalon-MM slave
package sbdma_pkg;
   localparam logic [3:0] CTRL_OFS   = 4'h0;
   localparam logic [3:0] ADDR_OFS   = 4'h4;
   localparam logic [3:0] DATA_OFS   = 4'h8;
   localparam logic [3:0] STAT_OFS   = 4'hc;
   localparam int CTRL_GO_BIT        = 0;
   localparam int CTRL_WRITE_BIT     = 1;
   localparam int CTRL_MODE_BIT      = 2;
   localparam int CTRL_WIDE_BIT      = 3;
   localparam int CTRL_BURST_BIT     = 4;
   localparam int CTRL_BYTE_BIT      = 5;
   localparam int CTRL_CNT_LSB       = 16;
   localparam int STAT_BUSY_BIT      = 0;
   localparam int STAT_ERR_BIT       = 1;
   localparam int STAT_DONE_BIT      = 2;
   localparam logic [31:0] CTRL_RST  = 32'h0000_0000;

   typedef enum logic [3:0] {
      SB_IDLE = 4'h0, SB_REQ = 4'h1, SB_OWN = 4'h2, SB_TXW = 4'h3,
      SB_TX = 4'h4, SB_T1 = 4'h5, SB_T2 = 4'h6, SB_T3 = 4'h7,
      SB_T4 = 4'h8, SB_REL = 4'h9, SB_GAP = 4'ha
   } sbdma_state_t;

   typedef struct packed {
      logic        write;
      logic        strobe_pair;
      logic        wide;
      logic        burst;
      logic        byte_only;
      logic [15:0] count;
   } sbdma_cfg_t;

   typedef struct packed {
      logic [15:0] ad_o;
      logic [15:0] ad_oe;
      logic [1:0]  par_o;
      logic [1:0]  par_oe;
   } sbdma_lane_t;
endpackage
